// File: bench/radio_spi_address_map_bench.sv
`timescale 1ns/1ps

module radio_spi_address_map_bench;
   import radio_map_pkg::*;
   logic        clk_sys, rst_n, sclkPin, csPin_n, mosiPin, misoOut, misoOe_n;
   logic        strobePulse, txQueuePush, rxQueuePop;
   logic [5:0]  strobeCode;
   byte_t       txQueueData;
   cfg_bank_t   cfgBank;
   power_bank_t powerTable;
   int          badCount, totalChecks, strobes, pushes, pops;
   // radio core status, distinct per field so a swapped field shows up
   byte_t       chipStatus = 8'hC3, freqOffsetEst = 8'h12, linkQualityEst = 8'h34, signalStrength = 8'h56;
   byte_t       synthCalSetting = 8'h78, rxQueueData = 8'h9C;
   logic [4:0]  radioFsmState = 5'h0D, packetFlags = 5'h1A;
   logic [15:0] wakeTimer = 16'hBEEF;
   logic [2:0]  generalDigitalOutputs = 3'h5;
   logic        txUnderflow = 1'b1, rxOverflow = 1'b0;
   logic [6:0]  txFill = 7'h21, rxFill = 7'h44;

   radio_spi_address_map dut_u (.clk_sys, .rst_n, .sclkPin, .csPin_n, .mosiPin, .misoOut, .misoOe_n,
      .chipStatus, .freqOffsetEst, .linkQualityEst, .signalStrength, .radioFsmState, .wakeTimer,
      .generalDigitalOutputs, .packetFlags, .synthCalSetting, .txUnderflow, .txFill, .rxOverflow,
      .rxFill, .strobePulse, .strobeCode, .txQueuePush, .txQueueData, .rxQueuePop, .rxQueueData,
      .cfgBank, .powerTable);
   spi_host_model host_u (.clk_sys, .sclkPin, .csPin_n, .mosiPin, .misoOut, .misoOe_n);

   ////////////////////////////////////////////////////////////////////////////
   // clock and pulse counters
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (strobePulse === 1'b1) strobes++;
      if (txQueuePush === 1'b1) pushes++;
      if (rxQueuePop === 1'b1) pops++;
   end

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      totalChecks++;
      if (s !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, s);
         badCount++;
      end
   endtask

   task automatic endSim();
      $display("checks %0d mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic test_reset();
      chk("cfg00", 8'h29, cfgBank[0]);
      chk("cfg01", 8'h2E, cfgBank[1]);
      chk("cfg02", 8'h3F, cfgBank[2]);
      chk("cfg03", 8'h07, cfgBank[3]);
      chk("pwr0", 8'h00, powerTable[0]);
      $display("test_reset done");
   endtask

   // single and burst, including a burst that runs past the last register
   task automatic test_cfg();
      host_u.frame(0, 0, 6'h05, 8'hAB, 1);
      chk("cfg05", 8'hAB, cfgBank[5]);
      host_u.frame(0, 1, 6'h2D, 8'h61, 3);
      chk("cfg2D", 8'h61, cfgBank[45]);
      chk("cfg2E", 8'h62, cfgBank[46]);
      host_u.frame(1, 0, 6'h05, 8'h00, 1);
      chk("rd05", 8'hAB, host_u.rxd);
      host_u.frame(1, 1, 6'h2E, 8'h00, 1);
      chk("rd2E", 8'h62, host_u.rxd);
      $display("test_cfg done");
   endtask

   task automatic test_status();
      byte_t ex [12];
      ex = '{8'h5A, 8'h01, freqOffsetEst, linkQualityEst, signalStrength, {3'b000, radioFsmState},
             wakeTimer[15:8], wakeTimer[7:0], {packetFlags, generalDigitalOutputs}, synthCalSetting,
             {txUnderflow, txFill}, {rxOverflow, rxFill}};
      for (int a = 0; a < 12; a++) begin
         host_u.frame(1, 1, 6'h30 + 6'(a), 8'h00, 1);
         chk("status", ex[a], host_u.rxd);
      end
      chk("strobes", 8'h00, 8'(strobes));
      $display("test_status done");
   endtask

   task automatic test_strobe();
      host_u.frame(0, 0, 6'h36, 8'h00, 0);
      chk("hdrByte", chipStatus, host_u.rxd);
      chk("code", 8'h36, {2'b00, strobeCode});
      host_u.frame(1, 0, 6'h38, 8'h00, 0);
      chk("code", 8'h38, {2'b00, strobeCode});
      host_u.frame(0, 0, 6'h3D, 8'h00, 0);
      chk("code", 8'h38, {2'b00, strobeCode});
      chk("strobes", 8'h02, 8'(strobes));
      // a burst write into the status range must change nothing
      host_u.frame(0, 1, 6'h35, 8'h99, 1);
      chk("cfg05keep", 8'hAB, cfgBank[5]);
      chk("pushNone", 8'h00, 8'(pushes));
      chk("strobes", 8'h02, 8'(strobes));
      // reset strobe returns the whole configuration bank to its reset values
      host_u.frame(0, 0, 6'h30, 8'h00, 0);
      chk("cfg05rst", 8'h00, cfgBank[5]);
      chk("cfg2Drst", 8'h00, cfgBank[45]);
      chk("cfg00rst", 8'h29, cfgBank[0]);
      chk("code", 8'h30, {2'b00, strobeCode});
      chk("strobes", 8'h03, 8'(strobes));
      $display("test_strobe done");
   endtask

   // queue window in burst write and single read, power table in all four access types
   task automatic test_window();
      host_u.frame(0, 1, 6'h3F, 8'h11, 2);
      chk("pushes", 8'h02, 8'(pushes));
      chk("txData", 8'h12, txQueueData);
      host_u.frame(1, 0, 6'h3F, 8'h00, 1);
      chk("rxData", rxQueueData, host_u.rxd);
      chk("pops", 8'h01, 8'(pops));
      host_u.frame(0, 1, 6'h3E, 8'hA0, 2);
      chk("pwr1", 8'hA1, powerTable[1]);
      host_u.frame(0, 0, 6'h3E, 8'hB0, 1);
      chk("pwr0", 8'hB0, powerTable[0]);
      host_u.frame(1, 1, 6'h3E, 8'h00, 2);
      chk("rdPwr1", 8'hA1, host_u.rxd);
      host_u.frame(1, 0, 6'h3E, 8'h00, 1);
      chk("rdPwr0", 8'hB0, host_u.rxd);
      $display("test_window done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence and hang guard
   initial begin
      rst_n = 1'b0;
      repeat (12) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      test_reset();
      test_cfg();
      test_status();
      test_strobe();
      test_window();
      endSim();
   end
   initial begin
      repeat (100000) @(posedge clk_sys);
      badCount++;
      endSim();
   end
endmodule

// File: bench/spi_host_model.sv
`timescale 1ns/1ps

module spi_host_model (
   // clock
   input  wire logic clk_sys,
   // serial pins
   output logic      sclkPin,
   output logic      csPin_n,
   output logic      mosiPin,
   input  wire logic misoOut,
   input  wire logic misoOe_n
);
   import radio_map_pkg::*;
   byte_t rxd;

   // idle: select high, serial clock low
   initial begin
      sclkPin = 1'b0;
      csPin_n = 1'b1;
      mosiPin = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one byte, mode 0; half period of 10 clk keeps the serial clock slow enough
   task automatic shift(input byte_t tx);
      for (int i = 7; i >= 0; i--) begin
         mosiPin = tx[i];
         repeat (10) @(negedge clk_sys);
         rxd[i] = misoOe_n ? 1'bx : misoOut;   // a released line never reads as data
         sclkPin = 1'b1;
         repeat (10) @(negedge clk_sys);
         sclkPin = 1'b0;
      end
   endtask

   // header then n data bytes d0, d0+1, ...; flush strobes are never sent by this bench
   task automatic frame(input logic rd, input logic bst, input logic [5:0] a, input byte_t d0, input int n);
      repeat (10) @(negedge clk_sys);
      csPin_n = 1'b0;
      repeat (10) @(negedge clk_sys);
      shift({rd, bst, a});
      for (int k = 0; k < n; k++) shift(d0 + 8'(k));
      repeat (10) @(negedge clk_sys);
      csPin_n = 1'b1;
      mosiPin = ~mosiPin;    // stale data bit is inverted once the frame ends
   endtask
endmodule

// File: design/radio_map_defs.svh
`ifndef RADIO_MAP_DEFS_SVH
`define RADIO_MAP_DEFS_SVH

// header byte layout
`define HDR_BURST_BIT      6
`define HDR_READ_BIT       7

// address space
`define CFG_LAST_ADDR      6'h2E
`define STROBE_FIRST_ADDR  6'h30
`define STROBE_LAST_ADDR   6'h3D
`define RESET_STROBE_ADDR  6'h30
`define NO_OP_STROBE_ADDR  6'h3D
`define POWER_TABLE_ADDR   6'h3E
`define DATA_QUEUE_ADDR    6'h3F

// status registers, reached by burst read only
`define PART_ID_ADDR       6'h30
`define REVISION_ADDR      6'h31
`define FREQ_OFFSET_ADDR   6'h32
`define LINK_QUALITY_ADDR  6'h33
`define SIGNAL_LEVEL_ADDR  6'h34
`define RADIO_STATE_ADDR   6'h35
`define WAKE_HIGH_ADDR     6'h36
`define WAKE_LOW_ADDR      6'h37
`define PIN_PACKET_ADDR    6'h38
`define SYNTH_CAL_ADDR     6'h39
`define TX_FILL_ADDR       6'h3A
`define RX_FILL_ADDR       6'h3B

// sizes
`define CFG_COUNT          47
`define POWER_TABLE_DEPTH  8

// configuration reset values
`define OUT_PIN2_CFG_ADDR  6'h00
`define OUT_PIN1_CFG_ADDR  6'h01
`define OUT_PIN0_CFG_ADDR  6'h02
`define QUEUE_THR_ADDR     6'h03
`define OUT_PIN2_CFG_RESET 8'h29
`define OUT_PIN1_CFG_RESET 8'h2E
`define OUT_PIN0_CFG_RESET 8'h3F
`define QUEUE_THR_RESET    8'h07
`define CFG_DEFAULT_RESET  8'h00

`endif

// File: design/radio_map_pkg.sv
`include "radio_map_defs.svh"

package radio_map_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [`CFG_COUNT-1:0][7:0] cfg_bank_t;
   typedef logic [`POWER_TABLE_DEPTH-1:0][7:0] power_bank_t;
   typedef enum logic [1:0] {
      ST_HEADER = 2'b01,
      ST_XFER   = 2'b10
   } map_state_t;
   typedef enum logic [2:0] {
      KIND_NONE   = 3'h0,
      KIND_CFG    = 3'h1,
      KIND_STATUS = 3'h2,
      KIND_POWER  = 3'h3,
      KIND_QUEUE  = 3'h4
   } access_kind_t;
endpackage

// File: design/radio_spi_address_map.sv
`timescale 1ns/1ps
`include "radio_map_defs.svh"

// What this block does
// - Addresses 0x00 to 0x2E are read/write configuration registers, reachable single or burst.
// - The header byte is the 6-bit address plus 0x40 for burst and 0x80 for read, decoded the same way here.
// - A single access, read or write, to 0x30..0x3D fires a command strobe instead of a transfer.
// - A burst read of 0x30..0x3B (headers 0xF0..0xFB) returns a status register, not a strobe.
// - 0x3E reaches the power table in all four access types; 0x3F writes the transmit queue and reads the receive queue.
// - Status 0x3A returns the transmit underflow flag and the transmit queue fill.
// - Status 0x3B returns the receive overflow flag and the receive queue fill.
// - Status 0x35 returns the present radio state machine code.
// - Status 0x36 and 0x37 return the high and low bytes of the wake timer.
// - Status 0x38 returns the general digital output levels and the packet status flags.
// - Status 0x32, 0x33, 0x34 return frequency offset, link quality and signal strength.
// - Status 0x39 returns the synthesizer calibration setting.
// - The strobe at 0x3D does nothing, so it can pad strobes or poll status.

module radio_spi_address_map #(
   parameter logic [7:0] PART_CODE = 8'h5A,   // arbitrary value
   parameter logic [7:0] REV_CODE  = 8'h01    // arbitrary value
) (
   // clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         rst_n,
   // serial host port pins
   input  wire logic                         sclkPin,
   input  wire logic                         csPin_n,
   input  wire logic                         mosiPin,
   output logic                              misoOut,
   output logic                              misoOe_n,
   // radio core status
   input  wire radio_map_pkg::byte_t         chipStatus,
   input  wire radio_map_pkg::byte_t         freqOffsetEst,
   input  wire radio_map_pkg::byte_t         linkQualityEst,
   input  wire radio_map_pkg::byte_t         signalStrength,
   input  wire logic [4:0]                   radioFsmState,
   input  wire logic [15:0]                  wakeTimer,
   input  wire logic [2:0]                   generalDigitalOutputs,
   input  wire logic [4:0]                   packetFlags,
   input  wire radio_map_pkg::byte_t         synthCalSetting,
   input  wire logic                         txUnderflow,
   input  wire logic [6:0]                   txFill,
   input  wire logic                         rxOverflow,
   input  wire logic [6:0]                   rxFill,
   // command strobes
   output logic                              strobePulse,
   output logic [5:0]                        strobeCode,
   // data queues
   output logic                              txQueuePush,
   output radio_map_pkg::byte_t              txQueueData,
   output logic                              rxQueuePop,
   input  wire radio_map_pkg::byte_t         rxQueueData,
   // configuration contents
   output radio_map_pkg::cfg_bank_t          cfgBank,
   output radio_map_pkg::power_bank_t        powerTable
);
   import radio_map_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pins and byte shifter

   logic [2:0] pinSync;
   logic       sclkSync, csSync_n, mosiSync;
   logic       byteDone;
   byte_t      rxByte;
   byte_t      txByte;

   // chip select idles high, so it resets high
   sync_2ff #(.WIDTH(3), .RESET_VAL(3'h2)) uPinSync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .din     ({sclkPin, csPin_n, mosiPin}),
      .dout    (pinSync)
   );
   assign sclkSync = pinSync[2];
   assign csSync_n = pinSync[1];
   assign mosiSync = pinSync[0];

   spi_byte_shifter uShift (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .sclkSync (sclkSync),
      .csSync_n (csSync_n),
      .mosiSync (mosiSync),
      .txByte   (txByte),
      .byteDone (byteDone),
      .rxByte   (rxByte),
      .misoOut  (misoOut),
      .misoOe_n (misoOe_n)
   );

   ////////////////////////////////////////////////////////////////////////////
   // header decode

   function automatic cfg_bank_t cfgResetValue();
      cfg_bank_t v;
      v = {`CFG_COUNT{`CFG_DEFAULT_RESET}};
      v[`OUT_PIN2_CFG_ADDR] = `OUT_PIN2_CFG_RESET;
      v[`OUT_PIN1_CFG_ADDR] = `OUT_PIN1_CFG_RESET;
      v[`OUT_PIN0_CFG_ADDR] = `OUT_PIN0_CFG_RESET;
      v[`QUEUE_THR_ADDR]    = `QUEUE_THR_RESET;
      return v;
   endfunction

   localparam cfg_bank_t CFG_RESET = cfgResetValue();

   logic [5:0]   hdrAddr;
   logic         hdrBurst, hdrRead, hdrStrobe;
   access_kind_t hdrKind;

   // burst-flagged accesses to the strobe range are never strobes
   always_comb begin
      hdrAddr   = rxByte[5:0];
      hdrBurst  = rxByte[`HDR_BURST_BIT];
      hdrRead   = rxByte[`HDR_READ_BIT];
      hdrStrobe = !hdrBurst && hdrAddr >= `STROBE_FIRST_ADDR
                  && hdrAddr <= `STROBE_LAST_ADDR;
      if (hdrAddr <= `CFG_LAST_ADDR)
         hdrKind = KIND_CFG;
      else if (hdrBurst && hdrRead && hdrAddr >= `PART_ID_ADDR && hdrAddr <= `RX_FILL_ADDR)
         hdrKind = KIND_STATUS;
      else if (hdrAddr == `POWER_TABLE_ADDR)
         hdrKind = KIND_POWER;
      else if (hdrAddr == `DATA_QUEUE_ADDR)
         hdrKind = KIND_QUEUE;
      else
         hdrKind = KIND_NONE;
   end

   // status register read mux
   function automatic byte_t statusValue(input logic [5:0] a);
      byte_t v;
      v = 8'h00;
      unique case (a)
         `PART_ID_ADDR:      v = PART_CODE;
         `REVISION_ADDR:     v = REV_CODE;
         `FREQ_OFFSET_ADDR:  v = freqOffsetEst;
         `LINK_QUALITY_ADDR: v = linkQualityEst;
         `SIGNAL_LEVEL_ADDR: v = signalStrength;
         `RADIO_STATE_ADDR:  v = {3'h0, radioFsmState};
         `WAKE_HIGH_ADDR:    v = wakeTimer[15:8];
         `WAKE_LOW_ADDR:     v = wakeTimer[7:0];
         `PIN_PACKET_ADDR:   v = {packetFlags, generalDigitalOutputs};
         `SYNTH_CAL_ADDR:    v = synthCalSetting;
         `TX_FILL_ADDR:      v = {txUnderflow, txFill};
         `RX_FILL_ADDR:      v = {rxOverflow, rxFill};
         default:            v = 8'h00;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // access state machine and register file

   map_state_t   stateReg, stateNext;
   logic [5:0]   addrReg, addrNext;
   logic         readReg, readNext;
   logic         burstReg, burstNext;
   access_kind_t kindReg, kindNext;
   logic [2:0]   powIdxReg, powIdxNext;
   cfg_bank_t    cfgReg, cfgNext;
   power_bank_t  powerReg, powerNext;
   logic         strobeReg, strobeNext;
   logic [5:0]   codeReg, codeNext;
   logic         pushReg, pushNext;
   byte_t        pushDataReg, pushDataNext;
   logic         popReg, popNext;
   logic         cfgHit, hdrDone, xferDone;

   assign cfgHit   = addrReg <= `CFG_LAST_ADDR;
   assign hdrDone  = byteDone && !csSync_n && stateReg == ST_HEADER;
   assign xferDone = byteDone && !csSync_n && stateReg == ST_XFER;

   // one header byte, then data bytes; a single access takes one data byte
   always_comb begin
      stateNext    = stateReg;
      addrNext     = addrReg;
      readNext     = readReg;
      burstNext    = burstReg;
      kindNext     = kindReg;
      powIdxNext   = powIdxReg;
      cfgNext      = cfgReg;
      powerNext    = powerReg;
      strobeNext   = 1'b0;
      codeNext     = codeReg;
      pushNext     = 1'b0;
      pushDataNext = pushDataReg;
      popNext      = 1'b0;
      if (csSync_n) begin
         // the table index restarts with every frame
         stateNext  = ST_HEADER;
         powIdxNext = 3'h0;
      end else if (byteDone) begin
         unique case (stateReg)
            ST_HEADER: begin
               addrNext  = hdrAddr;
               readNext  = hdrRead;
               burstNext = hdrBurst;
               if (hdrStrobe) begin
                  // next byte is a fresh header
                  if (hdrAddr != `NO_OP_STROBE_ADDR) begin
                     strobeNext = 1'b1;
                     codeNext   = hdrAddr;
                  end
                  if (hdrAddr == `RESET_STROBE_ADDR)
                     cfgNext = CFG_RESET;
               end else begin
                  stateNext = ST_XFER;
                  kindNext  = hdrKind;
               end
            end
            ST_XFER: begin
               if (!readReg) begin
                  unique case (kindReg)
                     KIND_CFG:   if (cfgHit) cfgNext[addrReg] = rxByte;
                     KIND_POWER: powerNext[powIdxReg] = rxByte;
                     KIND_QUEUE: begin
                        pushNext     = 1'b1;
                        pushDataNext = rxByte;
                     end
                     default: ;
                  endcase
               end else if (kindReg == KIND_QUEUE) begin
                  popNext = 1'b1;
               end
               if (!burstReg)
                  stateNext = ST_HEADER;
               else if (kindReg == KIND_CFG && cfgHit)
                  addrNext = addrReg + 6'h01;
               else if (kindReg == KIND_POWER)
                  powIdxNext = powIdxReg + 3'h1;
            end
            default: stateNext = ST_HEADER;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stateReg    <= ST_HEADER;
         addrReg     <= 6'h00;
         readReg     <= 1'b0;
         burstReg    <= 1'b0;
         kindReg     <= KIND_NONE;
         powIdxReg   <= 3'h0;
         cfgReg      <= CFG_RESET;
         powerReg    <= '0;
         strobeReg   <= 1'b0;
         codeReg     <= 6'h00;
         pushReg     <= 1'b0;
         pushDataReg <= 8'h00;
         popReg      <= 1'b0;
      end else begin
         stateReg    <= stateNext;
         addrReg     <= addrNext;
         readReg     <= readNext;
         burstReg    <= burstNext;
         kindReg     <= kindNext;
         powIdxReg   <= powIdxNext;
         cfgReg      <= cfgNext;
         powerReg    <= powerNext;
         strobeReg   <= strobeNext;
         codeReg     <= codeNext;
         pushReg     <= pushNext;
         pushDataReg <= pushDataNext;
         popReg      <= popNext;
      end
   end

   // byte offered to the shifter; the queue head is shown, then popped once sent
   always_comb begin
      txByte = chipStatus;
      if (stateReg == ST_XFER) begin
         unique case (kindReg)
            KIND_CFG:    txByte = cfgHit ? cfgReg[addrReg] : 8'h00;
            KIND_STATUS: txByte = statusValue(addrReg);
            KIND_POWER:  txByte = powerReg[powIdxReg];
            KIND_QUEUE:  txByte = rxQueueData;
            default:     txByte = 8'h00;
         endcase
      end
   end

   assign strobePulse = strobeReg;
   assign strobeCode  = codeReg;
   assign txQueuePush = pushReg;
   assign txQueueData = pushDataReg;
   assign rxQueuePop  = popReg;
   assign cfgBank     = cfgReg;
   assign powerTable  = powerReg;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   cfg_write_a: assert property (xferDone && !readReg && kindReg == KIND_CFG && cfgHit
      |=> cfgReg[$past(addrReg)] == $past(rxByte)) else $error("config write lost");
   hdr_decode_a: assert property (hdrDone && !hdrStrobe |=> stateReg == ST_XFER
      && {readReg, burstReg, addrReg} == $past(rxByte))
      else $error("header decoded wrongly");
   strobe_fire_a: assert property (hdrDone && hdrStrobe && hdrAddr != `NO_OP_STROBE_ADDR
      |=> strobePulse && strobeCode == $past(hdrAddr) && stateReg == ST_HEADER ##1 !strobePulse)
      else $error("strobe not fired once");
   status_read_a: assert property (hdrDone && rxByte[7:6] == 2'b11 && hdrAddr >= `PART_ID_ADDR
      && hdrAddr <= `RX_FILL_ADDR |=> kindReg == KIND_STATUS && !strobePulse) else $error("status read took a strobe");
   queue_push_a: assert property (xferDone && !readReg && kindReg == KIND_QUEUE
      |=> txQueuePush && txQueueData == $past(rxByte)) else $error("queue write missing");
   power_write_a: assert property (xferDone && !readReg && kindReg == KIND_POWER
      |=> powerTable[$past(powIdxReg)] == $past(rxByte)) else $error("power table write lost");
   tx_fill_a: assert property (stateReg == ST_XFER && kindReg == KIND_STATUS && addrReg == `TX_FILL_ADDR
      |-> txByte == {txUnderflow, txFill}) else $error("tx fill status wrong");
   rx_fill_a: assert property (stateReg == ST_XFER && kindReg == KIND_STATUS && addrReg == `RX_FILL_ADDR
      |-> txByte == {rxOverflow, rxFill}) else $error("rx fill status wrong");
   radio_state_a: assert property (stateReg == ST_XFER && kindReg == KIND_STATUS
      && addrReg == `RADIO_STATE_ADDR |-> txByte[4:0] == radioFsmState && txByte[7:5] == 3'h0)
      else $error("radio state status wrong");
   wake_low_a: assert property (stateReg == ST_XFER && kindReg == KIND_STATUS
      && addrReg == `WAKE_LOW_ADDR |-> txByte == wakeTimer[7:0]) else $error("wake timer status wrong");
   status_nowrite_a: assert property (xferDone && kindReg == KIND_NONE
      |=> $stable(cfgReg) && $stable(powerReg) && !txQueuePush) else $error("write to status had effect");
   no_op_a: assert property (hdrDone && !hdrBurst && hdrAddr == `NO_OP_STROBE_ADDR
      |=> !strobePulse && stateReg == ST_HEADER && $stable(cfgReg)) else $error("no-op strobe acted");

   strobe_seen_c: cover property (hdrDone && hdrStrobe ##1 strobePulse);
   burst_cfg_c:   cover property (xferDone && burstReg && kindReg == KIND_CFG ##[1:300] xferDone);
   queue_pop_c:   cover property (rxQueuePop);
   status_c:      cover property (hdrDone ##1 kindReg == KIND_STATUS);
endmodule

// File: design/spi_byte_shifter.sv
`timescale 1ns/1ps

module spi_byte_shifter (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   // synchronised pins
   input  wire logic                  sclkSync,
   input  wire logic                  csSync_n,
   input  wire logic                  mosiSync,
   // byte side
   input  wire radio_map_pkg::byte_t  txByte,
   output logic                       byteDone,
   output radio_map_pkg::byte_t       rxByte,
   // serial out
   output logic                       misoOut,
   output logic                       misoOe_n
);
   import radio_map_pkg::*;

   logic       sclkPrevReg, sclkPrevNext;
   logic       csPrevReg_n, csPrevNext_n;
   logic [2:0] bitCntReg, bitCntNext;
   byte_t      inReg, inNext;
   byte_t      outReg, outNext;
   byte_t      rxReg, rxNext;
   logic       doneReg, doneNext;
   logic       sclkRise, sclkFall, frameStart;

   // mode 0: sample on rising edge, shift out on falling edge
   always_comb begin
      sclkRise     = sclkSync & ~sclkPrevReg;
      sclkFall     = ~sclkSync & sclkPrevReg;
      frameStart   = ~csSync_n & csPrevReg_n;
      sclkPrevNext = sclkSync;
      csPrevNext_n = csSync_n;
      bitCntNext   = bitCntReg;
      inNext       = inReg;
      outNext      = outReg;
      rxNext       = rxReg;
      doneNext     = 1'b0;
      if (csSync_n) begin
         bitCntNext = 3'h0;
      end else if (frameStart) begin
         outNext = txByte;                 // status byte goes out with the header
      end else if (sclkRise) begin
         inNext     = {inReg[6:0], mosiSync};
         bitCntNext = bitCntReg + 3'h1;
         if (bitCntReg == 3'h7) begin
            rxNext   = {inReg[6:0], mosiSync};
            doneNext = 1'b1;
         end
      end else if (sclkFall) begin
         // a new byte is loaded on the fall that follows the eighth rise
         outNext = (bitCntReg == 3'h0) ? txByte : {outReg[6:0], 1'b0};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sclkPrevReg <= 1'b0;
         csPrevReg_n <= 1'b1;
         bitCntReg   <= 3'h0;
         inReg       <= 8'h00;
         outReg      <= 8'h00;
         rxReg       <= 8'h00;
         doneReg     <= 1'b0;
      end else begin
         sclkPrevReg <= sclkPrevNext;
         csPrevReg_n <= csPrevNext_n;
         bitCntReg   <= bitCntNext;
         inReg       <= inNext;
         outReg      <= outNext;
         rxReg       <= rxNext;
         doneReg     <= doneNext;
      end
   end

   assign byteDone = doneReg;
   assign rxByte   = rxReg;
   assign misoOut  = outReg[7];
   assign misoOe_n = csPrevReg_n;          // released while deselected
endmodule

// File: design/sync_2ff.sv
`timescale 1ns/1ps

module sync_2ff #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // asynchronous in, synchronised out
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] metaReg;
   logic [WIDTH-1:0] metaNext;
   logic [WIDTH-1:0] syncReg;
   logic [WIDTH-1:0] syncNext;

   // the first stage feeds only the second
   always_comb begin
      metaNext = din;
      syncNext = metaReg;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         metaReg <= RESET_VAL;
         syncReg <= RESET_VAL;
      end else begin
         metaReg <= metaNext;
         syncReg <= syncNext;
      end
   end

   assign dout = syncReg;
endmodule
